// file: shared/pgba_pkg.sv
// Constants and types for program page and data bank address formation.
// Assumes an APB master on pclk and a core sequencer issuing one-cycle requests.
//
// Notes on behaviour
// - Branch operands carry an 11-bit page offset
// - Branch page bits come from latch bits 4:3
// - Returns restore full 13-bit PC from stack
// - Up to 2K words: both page bits ignored
// - Up to 4K words: page bit 4 ignored
// - Bank controls live in status bits 7:5
// - Direct bank from high and low select
// - Indirect bank bit picks banks 0/1 or 2/3
// - Each bank spans 128 byte offsets
// - Last 16 bytes shared across all banks
// - Hot bank 0 registers mirrored in all banks
// - General RAM never reset
// - Some special registers reset, others keep contents
// - Register moves pass through accumulator, two cycles
// - Low byte write loads high bits from latch
// - Eight-entry wrapping return stack, no flags
package pgba_pkg;
	localparam int PC_W = 13;
	localparam int BRANCH_W = 11;
	localparam int OFFS_W = 7;
	localparam int DADDR_W = 9;
	localparam int STACK_DEPTH = 8;
	localparam int PAGE_WORDS = 2048;
	localparam int PROG_WORDS_MAX = 8192;
	localparam int COMMON_WORDS = 16;
	localparam logic [6:0] COMMON_BASE = 7'h70;
	localparam logic [6:0] BANK_TOP = 7'h7F;
	// Bank 0 registers seen at the same offset in every bank
	localparam int MIRROR_COUNT = 6;
	localparam logic [6:0] MIRROR_OFFS [MIRROR_COUNT] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B};
	// Bank bit positions within the status register
	localparam int STAT_IND_BIT = 7;
	localparam int STAT_HIGH_BIT = 6;
	localparam int STAT_LOW_BIT = 5;
	// APB register byte addresses
	localparam logic [7:0] OFS_UPPER_PC_LATCH = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INDIRECT_PTR = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0C;
	localparam logic [7:0] OFS_ACC = 8'h10;
	localparam logic [7:0] OFS_MOVE_CTRL = 8'h14;
	localparam logic [7:0] OFS_MOVE_STAT = 8'h18;
	localparam logic [7:0] OFS_COMMON_RAM = 8'h40;
	// Move control fields
	localparam int MOVE_SRC_LSB = 0;
	localparam int MOVE_DST_LSB = 8;
	// Reset values
	localparam logic [4:0] RST_UPPER_PC_LATCH = 5'h00;
	localparam logic [2:0] RST_BANK_BITS = 3'h0;
	localparam logic [PC_W-1:0] RST_PC = 13'h0000;

	typedef enum logic [2:0] {
		MV_IDLE = 3'b001,
		MV_LOAD = 3'b010,
		MV_STORE = 3'b100
	} pgba_move_t;
endpackage : pgba_pkg

// file: shared/pgba_stack_if.sv
// Interface between the address core and its return stack.
// Assumes push and pop are never both high in one cycle.
`timescale 1ns/1ps
interface pgba_stack_if;
	import pgba_pkg::*;
	logic push;
	logic pop;
	logic [PC_W-1:0] push_data;
	logic [PC_W-1:0] top;

	modport core (output push, output pop, output push_data, input top);
	modport stack (input push, input pop, input push_data, output top);
endinterface : pgba_stack_if

// file: src/pgba_return_stack.sv
// Eight-entry return address stack with wrapping pointer.
// Assumes push and pop are single-cycle strobes on pclk.
`timescale 1ns/1ps
module pgba_return_stack #(
	parameter int DEPTH = pgba_pkg::STACK_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	pgba_stack_if.stack stk
);
	import pgba_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);

	logic [PC_W-1:0] entries [DEPTH];
	logic [PTR_W-1:0] ptr;
	wire [PTR_W-1:0] ptr_below = ptr - 1'b1;

	assign stk.top = entries[ptr_below];

	// Pointer wraps silently; ninth push overwrites the oldest entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr <= '0;
		end else if (stk.push) begin
			ptr <= ptr + 1'b1;
		end else if (stk.pop) begin
			ptr <= ptr_below;
		end
	end

	always_ff @(posedge pclk) begin
		if (stk.push) begin
			entries[ptr] <= stk.push_data;
		end
	end
endmodule : pgba_return_stack

// file: src/pgba_addr_core.sv
// Program counter paging and data bank address formation with APB registers.
// Assumes the sequencer raises at most one program request per cycle.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module pgba_addr_core #(
	parameter int PROG_WORDS = pgba_pkg::PROG_WORDS_MAX,
	parameter bit HAS_COMMON_RAM = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic seq_step,
	input wire logic jump_req,
	input wire logic call_req,
	input wire logic ret_req,
	input wire logic pcl_write_req,
	input wire logic [pgba_pkg::BRANCH_W-1:0] branch_target,
	input wire logic [7:0] pcl_data,
	input wire logic data_req,
	input wire logic data_indirect,
	input wire logic [pgba_pkg::OFFS_W-1:0] data_offset,
	output logic [pgba_pkg::PC_W-1:0] prog_addr,
	output logic [pgba_pkg::DADDR_W-1:0] data_addr,
	output logic data_addr_valid,
	output logic move_busy
);
	import pgba_pkg::*;

	// =====================================================
	// Helpers
	// =====================================================
	// Ignored page bits stay stored; only branch formation drops them
	function automatic logic [1:0] page_bits(input logic [4:0] latch);
		logic [1:0] pg;
		pg = latch[4:3];
		if (PROG_WORDS <= PAGE_WORDS) begin
			pg = 2'b00;
		end else if (PROG_WORDS <= 2 * PAGE_WORDS) begin
			pg[1] = 1'b0;
		end
		return pg;
	endfunction : page_bits

	function automatic logic is_mirrored(input logic [OFFS_W-1:0] offs);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < MIRROR_COUNT; k++) begin
			if (offs == MIRROR_OFFS[k]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : is_mirrored

	// Shared tail and mirrored registers always resolve to bank 0
	function automatic logic [DADDR_W-1:0] form_addr(input logic [1:0] bank, input logic [OFFS_W-1:0] offs);
		logic [1:0] b;
		b = bank;
		if (HAS_COMMON_RAM && offs >= COMMON_BASE && offs <= BANK_TOP) begin
			b = 2'b00;
		end
		if (is_mirrored(offs)) begin
			b = 2'b00;
		end
		return {b, offs};
	endfunction : form_addr

	// =====================================================
	// State
	// =====================================================
	logic [4:0] upper_pc_latch;
	logic bank_select_low;
	logic bank_select_high;
	logic indirect_bank_select;
	logic [7:0] indirect_pointer_register;
	logic [7:0] working_accumulator;
	logic [PC_W-1:0] pc;
	logic [7:0] common_ram [COMMON_WORDS];
	pgba_move_t move_state;
	logic [3:0] move_src;
	logic [3:0] move_dst;

	pgba_stack_if stk ();

	// Returns restore all 13 bits; the latch is never consulted
	pgba_return_stack #(
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.stk(stk)
	);

	// =====================================================
	// APB decode
	// =====================================================
	wire apb_setup = psel && !penable;
	wire apb_done = psel && penable && pready;
	wire apb_wr = apb_done && pwrite;
	wire sel_latch = paddr == OFS_UPPER_PC_LATCH;
	wire sel_status = paddr == OFS_STATUS;
	wire sel_iptr = paddr == OFS_INDIRECT_PTR;
	wire sel_pc = paddr == OFS_PC;
	wire sel_acc = paddr == OFS_ACC;
	wire sel_mctl = paddr == OFS_MOVE_CTRL;
	wire sel_mstat = paddr == OFS_MOVE_STAT;
	wire sel_ram = paddr[7:6] == OFS_COMMON_RAM[7:6] && paddr[1:0] == 2'b00;
	wire [3:0] ram_idx = paddr[5:2];
	wire addr_ok = sel_latch || sel_status || sel_iptr || sel_pc || sel_acc ||
		sel_mctl || sel_mstat || sel_ram;
	wire mv_idle = move_state == MV_IDLE;
	wire move_start = apb_wr && sel_mctl && mv_idle;

	logic [31:0] read_mux;
	always_comb begin
		read_mux = 32'h0000_0000;
		if (sel_latch) begin
			read_mux[4:0] = upper_pc_latch;
		end
		if (sel_status) begin
			read_mux[STAT_IND_BIT] = indirect_bank_select;
			read_mux[STAT_HIGH_BIT] = bank_select_high;
			read_mux[STAT_LOW_BIT] = bank_select_low;
		end
		if (sel_iptr) begin
			read_mux[7:0] = indirect_pointer_register;
		end
		if (sel_pc) begin
			read_mux[PC_W-1:0] = pc;
		end
		if (sel_acc) begin
			read_mux[7:0] = working_accumulator;
		end
		if (sel_mctl) begin
			read_mux[MOVE_SRC_LSB +: 4] = move_src;
			read_mux[MOVE_DST_LSB +: 4] = move_dst;
		end
		if (sel_mstat) begin
			read_mux[0] = !mv_idle;
		end
		if (sel_ram) begin
			read_mux[7:0] = common_ram[ram_idx];
		end
	end

	// One wait-free access phase: pready rises for the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !addr_ok;
			if (apb_setup) begin
				prdata <= pwrite ? 32'h0000_0000 : read_mux;
			end
		end
	end

	// =====================================================
	// Core registers
	// =====================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_pc_latch <= RST_UPPER_PC_LATCH;
			{indirect_bank_select, bank_select_high, bank_select_low} <= RST_BANK_BITS;
		end else if (apb_wr && sel_latch) begin
			upper_pc_latch <= pwdata[4:0];
		end else if (apb_wr && sel_status) begin
			indirect_bank_select <= pwdata[STAT_IND_BIT];
			bank_select_high <= pwdata[STAT_HIGH_BIT];
			bank_select_low <= pwdata[STAT_LOW_BIT];
		end
	end

	// Pointer and accumulator keep their contents across reset
	always_ff @(posedge pclk) begin
		if (apb_wr && sel_iptr) begin
			indirect_pointer_register <= pwdata[7:0];
		end
	end

	// =====================================================
	// Program counter
	// =====================================================
	wire [PC_W-1:0] pc_inc = pc + 1'b1;
	wire [PC_W-1:0] branch_pc = {page_bits(upper_pc_latch), branch_target};
	wire [PC_W-1:0] pcl_pc = {upper_pc_latch, pcl_data};
	// Priority: return, branch, low-byte write, step
	wire take_ret = ret_req;
	wire take_branch = !ret_req && (call_req || jump_req);
	wire take_pcl = !ret_req && !call_req && !jump_req && pcl_write_req;
	wire take_step = !ret_req && !call_req && !jump_req && !pcl_write_req && seq_step;

	logic [PC_W-1:0] next_pc;
	always_comb begin
		next_pc = pc;
		if (take_ret) begin
			next_pc = stk.top;
		end else if (take_branch) begin
			next_pc = branch_pc;
		end else if (take_pcl) begin
			next_pc = pcl_pc;
		end else if (take_step) begin
			next_pc = pc_inc;
		end
	end

	assign stk.push = take_branch && call_req;
	assign stk.pop = ret_req;
	assign stk.push_data = pc_inc;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= RST_PC;
			prog_addr <= RST_PC;
		end else begin
			pc <= next_pc;
			prog_addr <= next_pc;
		end
	end

	// =====================================================
	// Data address
	// =====================================================
	// Indirect pair from the status bit, bank within it from pointer bit 7
	wire [1:0] direct_bank = {bank_select_high, bank_select_low};
	wire [1:0] indirect_bank = {indirect_bank_select, indirect_pointer_register[7]};
	wire [OFFS_W-1:0] eff_offset = data_indirect ? indirect_pointer_register[OFFS_W-1:0] : data_offset;
	wire [1:0] eff_bank = data_indirect ? indirect_bank : direct_bank;
	wire [DADDR_W-1:0] next_data_addr = form_addr(eff_bank, eff_offset);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_addr <= '0;
			data_addr_valid <= 1'b0;
		end else begin
			data_addr_valid <= data_req;
			if (data_req) begin
				data_addr <= next_data_addr;
			end
		end
	end

	// =====================================================
	// Register move through the accumulator
	// =====================================================
	pgba_move_t next_move_state;
	always_comb begin
		next_move_state = move_state;
		unique case (move_state)
			MV_IDLE: begin
				if (move_start) begin
					next_move_state = MV_LOAD;
				end
			end
			MV_LOAD: begin
				next_move_state = MV_STORE;
			end
			MV_STORE: begin
				next_move_state = MV_IDLE;
			end
			default: begin
				next_move_state = MV_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			move_state <= MV_IDLE;
			move_busy <= 1'b0;
			move_src <= 4'h0;
			move_dst <= 4'h0;
		end else begin
			move_state <= next_move_state;
			move_busy <= next_move_state != MV_IDLE;
			if (move_start) begin
				move_src <= pwdata[MOVE_SRC_LSB +: 4];
				move_dst <= pwdata[MOVE_DST_LSB +: 4];
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (move_state == MV_LOAD) begin
			working_accumulator <= common_ram[move_src];
		end
	end

	// Shared RAM has no reset; the move engine owns it while busy
	always_ff @(posedge pclk) begin
		if (move_state == MV_STORE) begin
			common_ram[move_dst] <= working_accumulator;
		end else if (apb_wr && sel_ram && mv_idle) begin
			common_ram[ram_idx] <= pwdata[7:0];
		end
	end
endmodule : pgba_addr_core

// file: tb/pgba_addr_core_assertions.sv
// Port checks for the address core.
// Assumes binding into pgba_addr_core on one clock.
`timescale 1ns/1ps
module pgba_chk #(
	parameter bit HAS_COMMON_RAM = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic jump_req,
	input wire logic call_req,
	input wire logic ret_req,
	input wire logic [pgba_pkg::BRANCH_W-1:0] branch_target,
	input wire logic data_req,
	input wire logic data_indirect,
	input wire logic [pgba_pkg::OFFS_W-1:0] data_offset,
	input wire logic [pgba_pkg::PC_W-1:0] prog_addr,
	input wire logic [pgba_pkg::DADDR_W-1:0] data_addr,
	input wire logic data_addr_valid,
	input wire logic move_busy
);
	import pgba_pkg::*;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_call;
		call_req && !ret_req;
	endsequence
	sequence s_ret;
		ret_req && !call_req;
	endsequence
	sequence s_mv;
		psel && penable && pready && pwrite && paddr == OFS_MOVE_CTRL && !move_busy;
	endsequence
	AST_SETUP_READY: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_DATA_VALID: assert property (data_req |=> data_addr_valid)
		else $error("data_addr_valid missing");
	AST_VALID_CAUSE: assert property (data_addr_valid |-> $past(data_req))
		else $error("data_addr_valid without request");
	AST_DIRECT_OFFS: assert property (data_req && !data_indirect |=> data_addr[6:0] == $past(data_offset))
		else $error("direct offset wrong");
	AST_COMMON: assert property (HAS_COMMON_RAM && data_req && data_offset >= COMMON_BASE
		&& !data_indirect |=> data_addr[8:7] == 2'h0)
		else $error("common bank not zero");
	AST_TARGET: assert property ((jump_req || call_req) && !ret_req
		|=> prog_addr[10:0] == $past(branch_target))
		else $error("branch offset wrong");
	AST_RETURN: assert property (s_call ##1 s_ret |=> prog_addr == $past(prog_addr, 2) + 13'h0001)
		else $error("return address wrong");
	AST_MOVE: assert property (s_mv |-> ##[1:2] ($rose(move_busy) ##0 move_busy [*2] ##1 !move_busy))
		else $error("move timing wrong");
endmodule : pgba_chk
bind pgba_addr_core pgba_chk #(.HAS_COMMON_RAM(HAS_COMMON_RAM)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.jump_req(jump_req), .call_req(call_req), .ret_req(ret_req), .branch_target(branch_target),
	.data_req(data_req), .data_indirect(data_indirect), .data_offset(data_offset), .prog_addr(prog_addr),
	.data_addr(data_addr), .data_addr_valid(data_addr_valid), .move_busy(move_busy));

// file: tb/pgba_seq_model.sv
// Sequencer model driving program flow strobes.
// Assumes the testbench calls op from one thread.
`timescale 1ns/1ps
module pgba_seq_model (
	input wire logic pclk,
	output logic [4:0] kind,
	output logic [pgba_pkg::BRANCH_W-1:0] branch_target,
	output logic [7:0] pcl_data
);
	import pgba_pkg::*;
	initial begin
		kind = 5'h00;
		branch_target = 11'h000;
		pcl_data = 8'h00;
	end
	// One strobe, held a cycle, then released
	task automatic op(input logic [4:0] k, input logic [10:0] t);
		@(posedge pclk);
		kind <= k;
		branch_target <= t;
		pcl_data <= t[7:0];
		@(posedge pclk);
		kind <= 5'h00;
		branch_target <= ~t;
		pcl_data <= ~t[7:0];
	endtask : op
	// Two strobes on consecutive edges, then released
	task automatic pair(input logic [4:0] k1, input logic [10:0] t, input logic [4:0] k2);
		@(posedge pclk);
		kind <= k1;
		branch_target <= t;
		@(posedge pclk);
		kind <= k2;
		@(posedge pclk);
		kind <= 5'h00;
	endtask : pair
endmodule : pgba_seq_model

// file: tb/tb_top.sv
// Self-checking bench for the address core.
// Assumes default parameters of the core.
`timescale 1ns/1ps
module tb_top;
	import pgba_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, data_req, data_indirect;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [6:0] data_offset;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, data_addr_valid, move_busy;
	wire logic [4:0] kind;
	wire logic [10:0] tg;
	wire logic [7:0] pd;
	wire logic [12:0] prog_addr, prog_addr_2k, prog_addr_4k;
	wire logic [8:0] data_addr;
	int errors, n_checks, cyc, i;
	logic [31:0] r;
	logic e, ind;
	logic [2:0] s;
	logic [7:0] p, d;
	logic [6:0] o;
	logic [4:0] l;
	logic [10:0] t;
	logic [12:0] pc;
	logic [12:0] q[$];
	pgba_seq_model m (.pclk(pclk), .kind(kind), .branch_target(tg), .pcl_data(pd));
	pgba_addr_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.seq_step(kind[4]), .jump_req(kind[3]), .call_req(kind[2]), .ret_req(kind[1]),
		.pcl_write_req(kind[0]), .branch_target(tg), .pcl_data(pd), .data_req(data_req),
		.data_indirect(data_indirect), .data_offset(data_offset), .prog_addr(prog_addr),
		.data_addr(data_addr), .data_addr_valid(data_addr_valid), .move_busy(move_busy));
	pgba_addr_core #(.PROG_WORDS(2 * PAGE_WORDS)) DUT_4K (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.seq_step(kind[4]), .jump_req(kind[3]), .call_req(kind[2]), .ret_req(kind[1]),
		.pcl_write_req(kind[0]), .branch_target(tg), .pcl_data(pd), .data_req(data_req),
		.data_indirect(data_indirect), .data_offset(data_offset), .prog_addr(prog_addr_4k),
		.data_addr(), .data_addr_valid(), .move_busy());
	pgba_addr_core #(.PROG_WORDS(PAGE_WORDS)) DUT_2K (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.seq_step(kind[4]), .jump_req(kind[3]), .call_req(kind[2]), .ret_req(kind[1]),
		.pcl_write_req(kind[0]), .branch_target(tg), .pcl_data(pd), .data_req(data_req),
		.data_indirect(data_indirect), .data_offset(data_offset), .prog_addr(prog_addr_2k),
		.data_addr(), .data_addr_valid(), .move_busy());
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			errors++;
			$display("Error %s expected %0h seen %0h", nm, ex, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	function automatic logic [8:0] exp_da(logic [2:0] st, logic [7:0] pt, logic id, logic [6:0] of);
		logic [6:0] f;
		logic [1:0] b;
		f = id ? pt[6:0] : of;
		b = id ? {st[2], pt[7]} : st[1:0];
		if (f >= COMMON_BASE)
			b = 2'h0;
		for (int k = 0; k < MIRROR_COUNT; k++)
			if (f == MIRROR_OFFS[k])
				b = 2'h0;
		return {b, f};
	endfunction : exp_da
	task automatic prog(input logic [4:0] k, input logic [10:0] a, input logic [12:0] ex);
		m.op(k, a);
		@(posedge pclk);
		chk("prog_addr", 32'(ex), 32'(prog_addr));
	endtask : prog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{data_req, data_indirect, data_offset} = '0;
		void'($urandom(32'h5affbb11));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_UPPER_PC_LATCH, 32'h0);
		chk("latch", 32'h0, r);
		apb(1'b0, 8'h30, 32'h0);
		chk("pslverr", 32'h1, 32'(e));
		$display("test reset done");
		// ====
		// Banked data addresses
		for (i = 0; i < 48; i++) begin
			{s, p, ind, o} = 19'($urandom);
			if (i < 8)
				{s, ind, o} = {i[2:0], i[2], 7'h25};
			apb(1'b1, OFS_STATUS, {24'h0, s, 5'h00});
			apb(1'b1, OFS_INDIRECT_PTR, {24'h0, p});
			@(posedge pclk);
			{data_req, data_indirect, data_offset} <= {1'b1, ind, o};
			@(posedge pclk);
			data_req <= 1'b0;
			@(posedge pclk);
			chk("data_addr", 32'(exp_da(s, p, ind, o)), 32'(data_addr));
			chk("data_addr_valid", 32'h1, 32'(data_addr_valid));
		end
		$display("test banking done");
		// ====
		// Paged calls, wrapping stack
		pc = 13'h0000;
		for (i = 0; i < 9; i++) begin
			{l, t} = 16'($urandom);
			apb(1'b1, OFS_UPPER_PC_LATCH, {27'h0, l});
			q.push_back(pc + 13'h0001);
			pc = {l[4:3], t};
			prog(5'h04, t, pc);
			chk("prog_addr_4k", 32'({1'b0, l[3], t}), 32'(prog_addr_4k));
			chk("prog_addr_2k", 32'({2'b00, t}), 32'(prog_addr_2k));
		end
		d = 8'($urandom);
		prog(5'h01, {3'h0, d}, {l, d});
		prog(5'h10, 11'h0, {l, d} + 13'h0001);
		for (i = 0; i < 8; i++)
			prog(5'h02, 11'h0, q.pop_back());
		t = 11'($urandom);
		pc = {l[4:3], t};
		prog(5'h08, t, pc);
		m.pair(5'h04, ~t, 5'h02);
		@(posedge pclk);
		chk("ret_after_call", 32'(pc + 13'h0001), 32'(prog_addr));
		$display("test paging done");
		// ====
		// Move and reset retention
		apb(1'b1, OFS_COMMON_RAM + 8'h0C, 32'h5A);
		apb(1'b1, OFS_MOVE_CTRL, 32'h0903);
		@(posedge pclk);
		chk("move_busy", 32'h1, 32'(move_busy));
		repeat (3) @(posedge pclk);
		chk("move_idle", 32'h0, 32'(move_busy));
		apb(1'b0, OFS_COMMON_RAM + 8'h24, 32'h0);
		chk("moved", 32'h5A, r);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_COMMON_RAM + 8'h24, 32'h0);
		chk("kept", 32'h5A, r);
		apb(1'b0, OFS_UPPER_PC_LATCH, 32'h0);
		chk("latch_reset", 32'h0, r);
		apb(1'b0, OFS_INDIRECT_PTR, 32'h0);
		chk("ptr_kept", {24'h0, p}, r);
		chk("pc_reset", 32'h0, 32'(prog_addr));
		$display("test move done");
		print_verdict();
	end
endmodule : tb_top
